//--- design/adcs_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses; bit 12 set selects the buffer)
// ----------------------------------------------------------------
`define ADCS_CTRL 13'h0000
`define ADCS_BLK 13'h0004
`define ADCS_BUFSZ 13'h0008
`define ADCS_RATE 13'h000C
`define ADCS_TIMER 13'h0010
`define ADCS_BURST 13'h0014
`define ADCS_CNTTHR 13'h0018
`define ADCS_STATUS 13'h001C
`define ADCS_MASK 13'h0020
`define ADCS_TRIG 13'h0024
`define ADCS_STATE 13'h0028
`define ADCS_GAIN 13'h002C
`define ADCS_BUF_SEL 12

// ----------------------------------------------------------------
// Control and gain register fields
// ----------------------------------------------------------------
`define ADCS_F_MODE 1:0
`define ADCS_F_TRIG_EXT 2
`define ADCS_F_TMR_REP 3
`define ADCS_F_FLAG_END 4
`define ADCS_F_GAIN_COM 5
`define ADCS_F_GAIN_X10 6
`define ADCS_F_SYNC_SLV 7
`define ADCS_F_GAIN_CH 5:0
`define ADCS_F_GAIN_VAL 8

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define ADCS_BLK_RST 3'h4
`define ADCS_BUF_RST 3'h6
`define ADCS_BUF_MAXCODE 3'h6
`define ADCS_BURST_MIN 11'h008
`define ADCS_BURST_MAX 11'h400

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADCS_CLK_HZ 250000000
`define ADCS_SCAN_MAX_HZ 100000
`define ADCS_SCAN_MIN_HZ 381
`define ADCS_TICK_US 10
`define ADCS_RATE_MIN_CYC (`ADCS_CLK_HZ / `ADCS_SCAN_MAX_HZ)
`define ADCS_RATE_MAX_CYC (`ADCS_CLK_HZ / `ADCS_SCAN_MIN_HZ)
`define ADCS_TICK_CYC (`ADCS_CLK_HZ / 1000000 * `ADCS_TICK_US)

`endif

//--- design/adcs_pkg.sv
// Types shared by the scan sequencer
package adcs_pkg;

	typedef enum logic [1:0] {S_IDLE, S_SYNC, S_CONV} adcs_st_t;

	typedef enum logic [1:0] {M_AUTO, M_TIMED, M_TRIG} adcs_mode_t;

	typedef struct packed {
		adcs_st_t st;
		adcs_mode_t mode;
		logic trig_ext;
		logic tmr_rep;
		logic flag_end;
		logic gain_com;
		logic gain_x10;
		logic sync_slv;
		logic [2:0] blk_code;
		logic [2:0] buf_code;
		logic [19:0] rate;
		logic [26:0] interval;
		logic [10:0] burst_len;
		logic [15:0] cnt_thr;
		logic [2:0] status;
		logic [2:0] mask;
		logic [63:0] gain_tbl;
		logic [5:0] ch;
		logic [9:0] wptr;
		logic [19:0] pace;
		logic [11:0] tick;
		logic [26:0] tmr;
		logic tmr_run;
		logic burst_on;
		logic [10:0] burst_cnt;
		logic [15:0] samp_cnt;
		logic ext_q;
		logic [31:0] rdata;
		logic irq;
		logic start;
		logic sync_out;
		logic gain_out;
		logic [5:0] ch_out;
	} adcs_state_t;

endpackage

//--- design/adcs_buf.sv
// Dual-port sample buffer: one write port, one independent read port
`timescale 1ns/1ps

module adcs_buf
	#(
	parameter int W = 16,
	parameter int AW = 10
	)
	(
	// Clock
	input wire logic clk,
	// Write side, fed by the sequencer
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [W-1:0] wr_data,
	// Read side, serves the host at any time
	input wire logic [AW-1:0] rd_addr,
	output logic [W-1:0] rd_data
	);

	logic [W-1:0] mem [0:(1<<AW)-1];

	// Storage write; no reset so it maps onto block memory
	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Read port never waits on the write port
	assign rd_data = mem[rd_addr];

endmodule

//--- design/adcs_seq.sv
// Scan and acquisition sequencer for a 64-channel 16-bit input board
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "adcs_regs.svh"

module adcs_seq
	import adcs_pkg::*;
	#(
	parameter int RATE_MAX_CYC = `ADCS_RATE_MAX_CYC,
	parameter int TICK_CYC = `ADCS_TICK_CYC
	)
	(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Register port
	input wire logic [12:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// Converter
	output logic ADC_START,
	output logic [5:0] ADC_CHAN,
	output logic ADC_GAIN_X10,
	input wire logic ADC_DONE,
	input wire logic [15:0] ADC_DATA,
	// Triggers and multi-board sync
	input wire logic EXT_TRIG,
	input wire logic SYNC_IN,
	output logic SYNC_OUT,
	// Interrupt
	output logic IRQ
	);

	// ------------------------------------------------------------
	// Constants
	// ------------------------------------------------------------
	localparam logic [19:0] RATE_MIN = 20'(`ADCS_RATE_MIN_CYC);
	localparam logic [19:0] RATE_MAX = 20'(RATE_MAX_CYC);
	localparam logic [11:0] TICK_LAST = 12'(TICK_CYC - 1);

	adcs_state_t q;
	adcs_state_t n;
	logic [15:0] buf_rd;
	logic buf_we;
	logic [6:0] blk_n;
	logic [5:0] ch_last;
	logic [5:0] ch_mid;
	logic [9:0] buf_last;
	logic [2:0] bcode;
	logic [2:0] ev;
	logic [2:0] clr;
	logic active;
	logic go;
	logic burst_go;
	logic sw_trig;
	logic trig;
	logic [10:0] blen;
	logic [19:0] rate_w;
	logic [12:0] wa;

	// ------------------------------------------------------------
	// Sample buffer
	// ------------------------------------------------------------
	adcs_buf #(.W(16), .AW(10)) i_adcs_buf
	(
		.clk(CLK),
		.wr_en(buf_we),
		.wr_addr(q.wptr),
		.wr_data(ADC_DATA),
		.rd_addr(ADDR[11:2]),
		.rd_data(buf_rd)
	);

	// Buffer write on each finished conversion
	assign buf_we = (q.st == S_CONV) && ADC_DONE;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		n = q;
		n.start = 1'b0;
		n.sync_out = 1'b0;
		ev = 3'h0;
		clr = 3'h0;
		go = 1'b0;
		burst_go = 1'b0;
		sw_trig = 1'b0;
		wa = {ADDR[12:2], 2'b00};

		// Block length decode, mid point is half the block
		unique case (q.blk_code)
			3'h0: blk_n = 7'd1;
			3'h1: blk_n = 7'd8;
			3'h2: blk_n = 7'd16;
			3'h3: blk_n = 7'd32;
			default: blk_n = 7'd64;
		endcase
		ch_last = 6'(blk_n - 7'd1);
		ch_mid = (blk_n == 7'd1) ? 6'd0 : 6'((blk_n >> 1) - 7'd1);

		// Buffer depth, codes past the top clamp to 1024 words
		bcode = (q.buf_code > `ADCS_BUF_MAXCODE) ?
			`ADCS_BUF_MAXCODE : q.buf_code;
		buf_last = 10'((11'd16 << bcode) - 11'd1);

		// Burst length and rate clamped into their legal span
		blen = WDATA[10:0];
		if (blen < `ADCS_BURST_MIN)
		begin
			blen = `ADCS_BURST_MIN;
		end
		else if (WDATA[31:11] != 21'h0 || blen > `ADCS_BURST_MAX)
		begin
			blen = `ADCS_BURST_MAX;
		end
		rate_w = WDATA[19:0];
		if (rate_w < RATE_MIN)
		begin
			rate_w = RATE_MIN;
		end
		else if (WDATA[31:20] != 12'h0 || rate_w > RATE_MAX)
		begin
			rate_w = RATE_MAX;
		end

		// Register writes
		if (WR && !ADDR[`ADCS_BUF_SEL])
		begin
			unique case (wa)
				`ADCS_CTRL:
				begin
					n.mode = adcs_mode_t'(WDATA[`ADCS_F_MODE]);
					n.trig_ext = WDATA[`ADCS_F_TRIG_EXT];
					n.tmr_rep = WDATA[`ADCS_F_TMR_REP];
					n.flag_end = WDATA[`ADCS_F_FLAG_END];
					n.gain_com = WDATA[`ADCS_F_GAIN_COM];
					n.gain_x10 = WDATA[`ADCS_F_GAIN_X10];
					n.sync_slv = WDATA[`ADCS_F_SYNC_SLV];
					// Any control write drops any burst and reloads the timer, which runs only if the write selects timed mode
					n.burst_on = 1'b0;
					n.tmr = q.interval;
					n.tmr_run = (WDATA[`ADCS_F_MODE] == 2'(M_TIMED));
				end
				`ADCS_BLK: n.blk_code = WDATA[2:0];
				`ADCS_BUFSZ: n.buf_code = WDATA[2:0];
				`ADCS_RATE: n.rate = rate_w;
				`ADCS_TIMER: n.interval = WDATA[26:0];
				`ADCS_BURST: n.burst_len = blen;
				`ADCS_CNTTHR: n.cnt_thr = WDATA[15:0];
				`ADCS_STATUS: clr = WDATA[2:0];
				`ADCS_MASK: n.mask = WDATA[2:0];
				`ADCS_TRIG: sw_trig = WDATA[0];
				`ADCS_GAIN:
					// Per-channel gain table entry
					n.gain_tbl[WDATA[`ADCS_F_GAIN_CH]] =
						WDATA[`ADCS_F_GAIN_VAL];
				default: ;
			endcase
		end

		// Register and buffer reads, answered one cycle later
		n.rdata = 32'h0;
		if (RD)
		begin
			if (ADDR[`ADCS_BUF_SEL])
			begin
				n.rdata = {16'h0, buf_rd};
			end
			else
			begin
				unique case (wa)
					`ADCS_CTRL: n.rdata = {24'h0, q.sync_slv, q.gain_x10,
						q.gain_com, q.flag_end, q.tmr_rep, q.trig_ext,
						q.mode};
					`ADCS_BLK: n.rdata = {29'h0, q.blk_code};
					`ADCS_BUFSZ: n.rdata = {29'h0, q.buf_code};
					`ADCS_RATE: n.rdata = {12'h0, q.rate};
					`ADCS_TIMER: n.rdata = {5'h0, q.interval};
					`ADCS_BURST: n.rdata = {21'h0, q.burst_len};
					`ADCS_CNTTHR: n.rdata = {16'h0, q.cnt_thr};
					`ADCS_STATUS: n.rdata = {29'h0, q.status};
					`ADCS_MASK: n.rdata = {29'h0, q.mask};
					`ADCS_STATE: n.rdata = {q.burst_on, q.tmr_run,
						q.st, 2'h0, q.ch, q.samp_cnt[9:0], q.wptr};
					`ADCS_GAIN: n.rdata = q.gain_tbl[31:0];
					default: n.rdata = 32'h0;
				endcase
			end
		end

		// Timer prescaler; a fixed tick keeps the interval counter small
		n.tick = (q.tick == TICK_LAST) ? 12'h0 : q.tick + 12'h1;
		if (q.tmr_run && q.tick == TICK_LAST && q.mode == M_TIMED)
		begin
			if (q.tmr == 27'h0)
			begin
				burst_go = 1'b1;
				n.tmr = q.interval;
				n.tmr_run = q.tmr_rep;
			end
			else
			begin
				n.tmr = q.tmr - 27'h1;
			end
		end

		// Trigger from software write or external rising edge
		n.ext_q = EXT_TRIG;
		trig = q.trig_ext ? (EXT_TRIG && !q.ext_q) : sw_trig;
		if (q.mode == M_TRIG && trig)
		begin
			burst_go = 1'b1;
		end
		if (burst_go && !q.burst_on)
		begin
			n.burst_on = 1'b1;
			n.burst_cnt = 11'h0;
		end

		// Autoscan runs free; burst modes only while a burst is open
		active = (q.mode == M_AUTO) || q.burst_on;

		// Sample pacing counter sets the scan rate
		if (q.pace != 20'h0)
		begin
			n.pace = q.pace - 20'h1;
		end

		// Conversion sequencing
		unique case (q.st)
			S_IDLE:
			begin
				if (active && q.pace == 20'h0)
				begin
					if (q.ch == 6'h0 && q.sync_slv)
					begin
						n.st = S_SYNC;
					end
					else
					begin
						go = 1'b1;
					end
				end
			end
			S_SYNC:
			begin
				// Slave holds the scan start until the shared pulse
				if (!active)
				begin
					n.st = S_IDLE;
				end
				else if (SYNC_IN)
				begin
					go = 1'b1;
				end
			end
			S_CONV:
			begin
				if (ADC_DONE)
				begin
					n.st = S_IDLE;
					// Oldest samples are overwritten on wrap
					n.wptr = (q.wptr >= buf_last) ? 10'h0 :
						q.wptr + 10'h1;
					n.ch = (q.ch >= ch_last) ? 6'h0 : q.ch + 6'h1;
					if (q.ch == (q.flag_end ? ch_last : ch_mid))
					begin
						ev[0] = 1'b1;
					end
					// Sample counter for the sample-count interrupt
					if (q.cnt_thr != 16'h0 &&
						q.samp_cnt + 16'h1 == q.cnt_thr)
					begin
						ev[1] = 1'b1;
						n.samp_cnt = 16'h0;
					end
					else
					begin
						n.samp_cnt = q.samp_cnt + 16'h1;
					end
					if (q.burst_on)
					begin
						n.burst_cnt = q.burst_cnt + 11'h1;
						if (q.burst_cnt + 11'h1 >= q.burst_len)
						begin
							n.burst_on = 1'b0;
							n.ch = 6'h0;
							ev[2] = 1'b1;
						end
					end
				end
			end
			default: n.st = S_IDLE;
		endcase

		// Launch one conversion; a master's scan start also drives the sync line
		if (go)
		begin
			n.start = 1'b1;
			n.ch_out = q.ch;
			n.gain_out = q.gain_com ? q.gain_x10 : q.gain_tbl[q.ch];
			n.sync_out = (q.ch == 6'h0) && !q.sync_slv;
			n.pace = q.rate - 20'h1;
			n.st = S_CONV;
		end

		// Sticky status, a new event wins over a same-cycle clear
		n.status = (q.status & ~clr) | ev;
		n.irq = |(n.status & n.mask);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			q <= '0;
			q.st <= S_IDLE;
			q.mode <= M_AUTO;
			q.blk_code <= `ADCS_BLK_RST;
			q.buf_code <= `ADCS_BUF_RST;
			q.rate <= RATE_MIN;
			q.burst_len <= `ADCS_BURST_MIN;
			q.gain_tbl <= 64'h0;
		end
		else
		begin
			q <= n;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all straight from the state register
	// ------------------------------------------------------------
	assign RDATA = q.rdata;
	assign ADC_START = q.start;
	assign ADC_CHAN = q.ch_out;
	assign ADC_GAIN_X10 = q.gain_out;
	assign SYNC_OUT = q.sync_out;
	assign IRQ = q.irq;

endmodule

//--- tb/adcs_conv_model.sv
// Behavioural converter that answers the sequencer's start pulses
`timescale 1ns/1ps

module adcs_conv_model
	(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Request from the sequencer
	input wire logic start,
	input wire logic [5:0] chan,
	input wire logic gain,
	// Short or long conversion time
	input wire logic slow,
	// Result
	output logic done,
	output logic [15:0] data
	);
	int cnt;

	// Result word tags channel and gain; the line is inverted outside the
	// done cycle so a stale value is never taken for a fresh one
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt <= 0;
			done <= 1'b0;
			data <= 16'h0000;
		end
		else
		begin
			cnt <= start ? (slow ? 200 : 3) : (cnt != 0 ? cnt - 1 : 0);
			done <= (cnt == 1);
			data <= (cnt == 1) ? {gain ? 8'hA0 : 8'h50, 2'h0, chan} : ~data;
		end
	end
endmodule

//--- tb/adcs_seq_properties.sv
// Port-level assertions for the scan sequencer
`timescale 1ns/1ps

module adcs_seq_checker
	(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Register port
	input wire logic WR,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	// Converter, sync and interrupt
	input wire logic ADC_START,
	input wire logic [5:0] ADC_CHAN,
	input wire logic ADC_GAIN_X10,
	input wire logic ADC_DONE,
	input wire logic SYNC_OUT,
	input wire logic IRQ
	);
	localparam int GAP_MIN = 2499;
	logic [11:0] gap_q;
	logic [5:0] last_q;
	logic seen_q;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);

	// Gap counter saturates so long idle spells never wrap round
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			gap_q <= 12'hFFF;
			last_q <= 6'h00;
			seen_q <= 1'b0;
		end
		else
		begin
			gap_q <= ADC_START ? 12'h000 : gap_q + {11'h000, gap_q != 12'hFFF};
			last_q <= ADC_START ? ADC_CHAN : last_q;
			seen_q <= seen_q | ADC_START;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	sequence s_first_start;
		##[0:2] (ADC_START && ADC_CHAN == 6'h00 && !ADC_GAIN_X10);
	endsequence

	a_reset_first_start: assert property ($fell(RESET) |-> s_first_start)
		else $error("no unity-gain start on channel 0 after reset");
	a_start_one_cycle: assert property (ADC_START |=> (!ADC_START)[*8])
		else $error("start pulse longer than one cycle");
	a_chan_held: assert property (!ADC_START |-> $stable(ADC_CHAN))
		else $error("channel changed without a start");
	a_start_rate: assert property (ADC_START |-> gap_q >= GAP_MIN)
		else $error("starts closer than the top scan rate");
	a_chan_ascend: assert property (ADC_START && seen_q |->
		ADC_CHAN == 6'h00 || ADC_CHAN == last_q + 6'h01)
		else $error("channel order not ascending");
	a_sync_scan_start: assert property (SYNC_OUT |->
		ADC_START && ADC_CHAN == 6'h00)
		else $error("sync pulse not at a scan start");
	// Status and interrupt register on the same edge as the event or write
	a_irq_rise_cause: assert property ($rose(IRQ) |->
		$past(ADC_DONE, 1) || $past(WR, 1))
		else $error("interrupt rose without an event");
	a_irq_fall_cause: assert property ($fell(IRQ) |-> $past(WR, 1))
		else $error("interrupt fell without a write");
	a_rdata_idle: assert property (!RD |=> RDATA == 32'h00000000)
		else $error("read data outside the answer cycle");
endmodule

bind adcs_seq adcs_seq_checker i_chk (.CLK, .RESET, .WR, .RD, .RDATA,
	.ADC_START, .ADC_CHAN, .ADC_GAIN_X10, .ADC_DONE, .SYNC_OUT, .IRQ);

//--- tb/adcs_seq_tb.sv
// Self-checking bench for the scan sequencer
`timescale 1ns/1ps
`include "adcs_regs.svh"

module adcs_seq_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic trig = 1'b0;
	logic sync_i = 1'b0;
	logic slow = 1'b0;
	logic [12:0] addr = 13'h0000;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] rdata;
	logic [31:0] d;
	logic start, gain, sync_o, irq, done;
	logic [5:0] chan;
	logic [15:0] adata;
	logic [6:0] starts[$];
	int n_mismatch = 0;
	int num_checks = 0;
	int n_conv = 0;
	int n_sync = 0;

	always #2 clk = ~clk;

	// Short tick keeps the timer counts small in simulation
	adcs_seq #(.TICK_CYC(4)) i_adcs_seq (.CLK(clk), .RESET(rst), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .ADC_START(start),
		.ADC_CHAN(chan), .ADC_GAIN_X10(gain), .ADC_DONE(done),
		.ADC_DATA(adata), .EXT_TRIG(trig), .SYNC_IN(sync_i),
		.SYNC_OUT(sync_o), .IRQ(irq));
	adcs_conv_model i_adcs_conv_model (.clk(clk), .rst(rst), .start(start),
		.chan(chan), .gain(gain), .slow(slow), .done(done), .data(adata));

	// Record every start, count finished conversions and sync pulses
	always @(posedge clk)
	begin
		if (start === 1'b1)
			starts.push_back({gain, chan});
		if (done === 1'b1)
			n_conv++;
		if (sync_o === 1'b1)
			n_sync++;
	end

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task wr_reg(input logic [12:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Data are taken at the edge that closes the one cycle they stand
	task rd_reg(input logic [12:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask

	task wait_starts(input int n);
		int k;
		k = 0;
		while (starts.size() < n && k < 40000)
		begin
			@(posedge clk);
			k++;
		end
		chk(starts.size() >= n, 1'b1);
	endtask

	// Eight bursts samples then silence, channels from 0 when c0 is set
	task burst_check(input logic c0);
		wait_starts(8);
		repeat (3000) @(posedge clk);
		chk(starts.size(), 8);
		for (int i = 0; i < 8; i++)
			if (c0)
				chk(starts[i], {1'b1, 6'(i)});
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_autoscan;
		wr_reg(`ADCS_BUFSZ, 32'h0);
		wr_reg(`ADCS_BLK, 32'h1);
		wr_reg(`ADCS_MASK, 32'h1);
		wr_reg(`ADCS_CTRL, 32'h10);
		wr_reg(`ADCS_GAIN, 32'h103);
		rd_reg(`ADCS_GAIN);
		chk(d, 32'h8);
		rd_reg(13'h00FC);
		chk(d, 32'h0);
		// Endscan selected: no flag once channel 3 is done
		wait_starts(5);
		rd_reg(`ADCS_STATUS);
		chk(d[0], 1'b0);
		wait_starts(9);
		for (int i = 0; i < 9; i++)
			chk(starts[i], {i == 3, 6'(i % 8)});
		chk(n_sync, 2);
		chk(irq, 1'b1);
		rd_reg(`ADCS_STATUS);
		chk(d[0], 1'b1);
		wr_reg(`ADCS_MASK, 32'h0);
		repeat (4) @(posedge clk);
		chk(irq, 1'b0);
		wr_reg(`ADCS_STATUS, 32'h7);
		wr_reg(`ADCS_MASK, 32'h1);
		repeat (4) @(posedge clk);
		chk(irq, 1'b0);
		for (int i = 0; i < 8; i++)
		begin
			rd_reg(13'h1000 + 13'(i * 4));
			chk(d[15:0], {i == 3 ? 8'hA0 : 8'h50, 8'(i)});
		end
	endtask

	task t_common_and_bursts;
		int n;
		wr_reg(`ADCS_CTRL, 32'h70);
		n = starts.size();
		wait_starts(n + 1);
		chk(starts[n][6], 1'b1);
		wr_reg(`ADCS_MASK, 32'h4);
		wr_reg(`ADCS_BURST, 32'h8);
		wr_reg(`ADCS_CTRL, 32'h62);
		repeat (2) @(posedge clk);
		starts.delete();
		wr_reg(`ADCS_STATUS, 32'h7);
		wr_reg(`ADCS_TRIG, 32'h1);
		burst_check(1'b0);
		chk(irq, 1'b1);
		rd_reg(`ADCS_STATUS);
		chk(d[2], 1'b1);
		wr_reg(`ADCS_STATUS, 32'h7);
		slow <= 1'b1;
		// Count interrupt due on the sixth sample of the next burst
		wr_reg(`ADCS_CNTTHR, 32'(n_conv + 6));
		wr_reg(`ADCS_CTRL, 32'h66);
		repeat (2) @(posedge clk);
		starts.delete();
		trig <= 1'b1;
		repeat (3) @(posedge clk);
		trig <= 1'b0;
		// Midscan selected: flag after channel 3, count not yet reached
		wait_starts(5);
		rd_reg(`ADCS_STATUS);
		chk(d[2:0], 3'h1);
		burst_check(1'b1);
		rd_reg(`ADCS_STATUS);
		chk(d[2:0], 3'h7);
	endtask

	// Slave waits for the shared pulse; then repeat and single-shot timer
	task t_sync_and_timer;
		int k;
		int ns;
		ns = n_sync;
		wr_reg(`ADCS_CTRL, 32'h80);
		starts.delete();
		repeat (100) @(posedge clk);
		chk(starts.size(), 0);
		sync_i <= 1'b1;
		@(posedge clk);
		sync_i <= 1'b0;
		repeat (2) @(posedge clk);
		chk(starts.size(), 1);
		chk(n_sync, ns);
		// Park in idle until the pace counter has run out
		wr_reg(`ADCS_CTRL, 32'h02);
		wr_reg(`ADCS_TIMER, 32'h14);
		repeat (2600) @(posedge clk);
		starts.delete();
		wr_reg(`ADCS_CTRL, 32'h09);
		k = 0;
		while (starts.size() == 0 && k < 200)
		begin
			@(posedge clk);
			k++;
		end
		// 21 ticks of 4 cycles, plus tick phase and launch
		chk(k >= 80 && k <= 90, 1'b1);
		rd_reg(`ADCS_STATE);
		chk(d[31:30], 2'h3);
		wr_reg(`ADCS_CTRL, 32'h01);
		repeat (300) @(posedge clk);
		rd_reg(`ADCS_STATE);
		chk(d[31:30], 2'h2);
		wr_reg(`ADCS_CTRL, 32'h02);
		repeat (300) @(posedge clk);
		rd_reg(`ADCS_STATE);
		chk(d[9:0], 10'(n_conv % 16));
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		#400000;
		$display("ERROR %0t: watchdog expired", $time);
		n_mismatch++;
		end_sim();
	end

	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_autoscan();
		t_common_and_bursts();
		t_sync_and_timer();
		end_sim();
	end
endmodule
